// *** shared/tmc_pkg.sv ***
// package: register map, field layout and carriers of the compare/capture timer
// ---------------------------------------------------------------------------
// What this block does
// - compare hit with clear-on-hit bit resets tick count; bits 10,7,4,1.
// - compare hit with halt-on-hit bit stops counters, clears run bit.
// - compare hit with irq-on-hit bit raises interrupt; bits 9,6,3,0.
// - all compare-action bits reset to zero.
// - four writable 32-bit compare values, each resetting to zero.
// - each compare value is the equality match value for tick count.
// - rising edge is a sampled low followed by a sampled high.
// - falling edge is a sampled high followed by a sampled low.
// - each capture channel has rising and falling enable bits.
// - enabled edge loads tick count into channel's captured value.
// - capture load with capture interrupt enable raises interrupt.
// - rising and falling enables together capture on both edges.
// - reset clears the whole capture setup register.
// - channel 3 capture: irq enable bit 11, falling 10, rising 9.
// - bits 31 to 12 of both setup registers read zero.
// - channel 3 falling enable loads channel 3 capture on high-to-low.
// - halt-on-hit takes priority over clear-on-hit.
// - channel 3 halt-on-hit enable is compare-action bit 11.
// - interrupt flags clear on writing one; writing zero leaves them.
// - tick count advances by one every prescale cycle.
// ---------------------------------------------------------------------------
package tmc_pkg;

  localparam int unsigned TMC_CHANNELS = 4;
  localparam int unsigned TMC_AW = 12;

  // ---------------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [TMC_AW-1:0] TMC_OFF_FLAGS = 12'h000;
  localparam logic [TMC_AW-1:0] TMC_OFF_RUN_CTRL = 12'h004;
  localparam logic [TMC_AW-1:0] TMC_OFF_TICK = 12'h008;
  localparam logic [TMC_AW-1:0] TMC_OFF_PRESCALE_MAX = 12'h00c;
  localparam logic [TMC_AW-1:0] TMC_OFF_PRESCALE_CNT = 12'h010;
  localparam logic [TMC_AW-1:0] TMC_OFF_COMPARE_ACTION = 12'h014;
  localparam logic [TMC_AW-1:0] TMC_OFF_COMPARE_VALUE0 = 12'h018;
  localparam logic [TMC_AW-1:0] TMC_OFF_CAPTURE_SETUP = 12'h028;
  localparam logic [TMC_AW-1:0] TMC_OFF_CAPTURED0 = 12'h02c;
  localparam logic [TMC_AW-1:0] TMC_OFF_LAST = 12'h038;

  // ---------------------------------------------------------------------------
  // field layout: three bits per channel in both setup registers
  // ---------------------------------------------------------------------------
  localparam int unsigned TMC_STRIDE = 3;
  localparam int unsigned TMC_CMP_IRQ = 0;
  localparam int unsigned TMC_CMP_CLEAR = 1;
  localparam int unsigned TMC_CMP_HALT = 2;
  localparam int unsigned TMC_CAP_RISE = 0;
  localparam int unsigned TMC_CAP_FALL = 1;
  localparam int unsigned TMC_CAP_IRQ = 2;
  localparam int unsigned TMC_SETUP_W = 12;
  localparam int unsigned TMC_FLAG_CAP = 4;
  localparam int unsigned TMC_FLAG_W = 8;
  localparam int unsigned TMC_RUN_BIT = 0;
  localparam int unsigned TMC_CRST_BIT = 1;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [TMC_SETUP_W-1:0] TMC_SETUP_RST = 12'h000;
  localparam logic [31:0] TMC_WORD_RST = 32'h0000_0000;
  localparam logic [TMC_FLAG_W-1:0] TMC_FLAGS_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // bus carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [TMC_AW-1:0] paddr;
    logic [31:0] pwdata;
  } tmc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tmc_apb_rsp_t;

endpackage : tmc_pkg

// *** rtl/tmc_timer_match_capture.sv ***
// compare-and-capture timer core with its apb register file
`timescale 1ns/1ps
`default_nettype none

module tmc_timer_match_capture
  import tmc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire tmc_pkg::tmc_apb_req_t apb_req,
  output var tmc_pkg::tmc_apb_rsp_t apb_rsp,
  // capture pins
  input wire logic [3:0] cap_in,
  // interrupt request, or of all flags
  output var logic irq
);
  import tmc_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [TMC_SETUP_W-1:0] compare_action_setup;
    logic [3:0][31:0] compare_value;
    logic [TMC_SETUP_W-1:0] capture_setup;
    logic [3:0][31:0] captured_value;
    logic [3:0] cap_prev;
    logic [TMC_FLAG_W-1:0] flags;
    logic run;
    logic crst;
    logic [31:0] prescale_max;
    logic [31:0] prescale_cnt;
    logic [31:0] tick_count;
    tmc_apb_rsp_t rsp;
    logic irq;
  } tmc_state_t;

  tmc_state_t s;
  tmc_state_t next_s;

  // ---------------------------------------------------------------------------
  // address decode and read mux
  // ---------------------------------------------------------------------------
  function automatic logic tmc_mapped(input logic [TMC_AW-1:0] a);
    tmc_mapped = (a[1:0] == 2'h0) && (a <= TMC_OFF_LAST);
  endfunction

  function automatic logic [31:0] tmc_read(input tmc_state_t st,
                                           input logic [TMC_AW-1:0] a);
    logic [31:0] v;
    v = TMC_WORD_RST;
    if (a == TMC_OFF_FLAGS)
      v[TMC_FLAG_W-1:0] = st.flags;
    else if (a == TMC_OFF_RUN_CTRL)
    begin
      v[TMC_RUN_BIT] = st.run;
      v[TMC_CRST_BIT] = st.crst;
    end
    else if (a == TMC_OFF_TICK)
      v = st.tick_count;
    else if (a == TMC_OFF_PRESCALE_MAX)
      v = st.prescale_max;
    else if (a == TMC_OFF_PRESCALE_CNT)
      v = st.prescale_cnt;
    else if (a == TMC_OFF_COMPARE_ACTION)
      v[TMC_SETUP_W-1:0] = st.compare_action_setup;
    else if (a == TMC_OFF_CAPTURE_SETUP)
      v[TMC_SETUP_W-1:0] = st.capture_setup;
    else if (a >= TMC_OFF_COMPARE_VALUE0 && a < TMC_OFF_CAPTURE_SETUP)
      v = st.compare_value[2'((a - TMC_OFF_COMPARE_VALUE0) >> 2)];
    else if (a >= TMC_OFF_CAPTURED0 && a <= TMC_OFF_LAST)
      v = st.captured_value[2'((a - TMC_OFF_CAPTURED0) >> 2)];
    tmc_read = v;
  endfunction

  // ---------------------------------------------------------------------------
  // compare and edge detection
  // ---------------------------------------------------------------------------
  logic [3:0] hit;
  logic [3:0] hit_irq;
  logic [3:0] hit_clear;
  logic [3:0] hit_halt;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] cap_evt;
  logic [3:0] cap_irq;

  for (genvar i = 0; i < TMC_CHANNELS; i++)
  begin : g_ch
    // compared against the registered count every clock
    assign hit[i] = (s.compare_value[i] == s.tick_count);
    assign hit_irq[i] = hit[i] &
      s.compare_action_setup[i*TMC_STRIDE+TMC_CMP_IRQ];
    assign hit_clear[i] = hit[i] &
      s.compare_action_setup[i*TMC_STRIDE+TMC_CMP_CLEAR];
    assign hit_halt[i] = hit[i] &
      s.compare_action_setup[i*TMC_STRIDE+TMC_CMP_HALT];
    assign rise[i] = ~s.cap_prev[i] & cap_in[i];
    assign fall[i] = s.cap_prev[i] & ~cap_in[i];
    // both enables may be set; either edge then captures
    assign cap_evt[i] =
      (rise[i] & s.capture_setup[i*TMC_STRIDE+TMC_CAP_RISE]) |
      (fall[i] & s.capture_setup[i*TMC_STRIDE+TMC_CAP_FALL]);
    assign cap_irq[i] = cap_evt[i] &
      s.capture_setup[i*TMC_STRIDE+TMC_CAP_IRQ];
  end

  // ---------------------------------------------------------------------------
  // bus qualifiers
  // ---------------------------------------------------------------------------
  logic setup_phase;
  logic access_done;
  logic wr_ok;
  logic [TMC_AW-1:0] wa;
  logic [31:0] wd;

  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign access_done = apb_req.psel & apb_req.penable & s.rsp.pready;
  assign wr_ok = access_done & apb_req.pwrite & tmc_mapped(apb_req.paddr);
  assign wa = apb_req.paddr;
  assign wd = apb_req.pwdata;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic [TMC_FLAG_W-1:0] flag_clr;
    flag_clr = '0;
    next_s = s;

    // prescaler and tick count
    if (s.crst)
    begin
      next_s.prescale_cnt = TMC_WORD_RST;
      next_s.tick_count = TMC_WORD_RST;
    end
    else if (s.run)
    begin
      if (s.prescale_cnt >= s.prescale_max)
      begin
        next_s.prescale_cnt = TMC_WORD_RST;
        next_s.tick_count = s.tick_count + 32'h0000_0001;
      end
      else
        next_s.prescale_cnt = s.prescale_cnt + 32'h0000_0001;
    end

    // software writes
    if (wr_ok)
    begin
      if (wa == TMC_OFF_FLAGS)
        flag_clr = wd[TMC_FLAG_W-1:0];
      else if (wa == TMC_OFF_RUN_CTRL)
      begin
        next_s.run = wd[TMC_RUN_BIT];
        next_s.crst = wd[TMC_CRST_BIT];
      end
      else if (wa == TMC_OFF_TICK)
        next_s.tick_count = wd;
      else if (wa == TMC_OFF_PRESCALE_MAX)
        next_s.prescale_max = wd;
      else if (wa == TMC_OFF_COMPARE_ACTION)
        next_s.compare_action_setup = wd[TMC_SETUP_W-1:0];
      else if (wa == TMC_OFF_CAPTURE_SETUP)
        next_s.capture_setup = wd[TMC_SETUP_W-1:0];
      else if (wa >= TMC_OFF_COMPARE_VALUE0 && wa < TMC_OFF_CAPTURE_SETUP)
        next_s.compare_value[2'((wa - TMC_OFF_COMPARE_VALUE0) >> 2)] = wd;
    end

    // compare actions override software: halt first, then clear
    if (|hit_halt)
    begin
      next_s.run = 1'b0;
      next_s.prescale_cnt = s.prescale_cnt;
      next_s.tick_count = s.tick_count;
    end
    else if (|hit_clear)
    begin
      next_s.prescale_cnt = TMC_WORD_RST;
      next_s.tick_count = TMC_WORD_RST;
    end

    // captures take the count seen by the edge sample
    for (int i = 0; i < TMC_CHANNELS; i++)
    begin
      if (cap_evt[i])
        next_s.captured_value[i] = s.tick_count;
    end
    next_s.cap_prev = cap_in;

    // a new event in the clear cycle survives the clear
    next_s.flags = (s.flags & ~flag_clr) | {cap_irq, hit_irq};
    next_s.irq = |next_s.flags;

    // bus answer: data fetched in setup, one access cycle
    if (setup_phase)
    begin
      next_s.rsp.pready = 1'b1;
      next_s.rsp.pslverr = ~tmc_mapped(wa);
      if (!apb_req.pwrite && tmc_mapped(wa))
        next_s.rsp.prdata = tmc_read(s, wa);
      else
        next_s.rsp.prdata = TMC_WORD_RST;
    end
    else if (access_done)
    begin
      next_s.rsp.pready = 1'b0;
      next_s.rsp.pslverr = 1'b0;
      next_s.rsp.prdata = TMC_WORD_RST;
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s.compare_action_setup <= TMC_SETUP_RST;
      s.compare_value <= '0;
      s.capture_setup <= TMC_SETUP_RST;
      s.captured_value <= '0;
      s.cap_prev <= 4'h0;
      s.flags <= TMC_FLAGS_RST;
      s.run <= 1'b0;
      s.crst <= 1'b0;
      s.prescale_max <= TMC_WORD_RST;
      s.prescale_cnt <= TMC_WORD_RST;
      s.tick_count <= TMC_WORD_RST;
      s.rsp <= '0;
      s.irq <= 1'b0;
    end
    else
      s <= next_s;
  end

  assign apb_rsp = s.rsp;
  assign irq = s.irq;

endmodule // tmc_timer_match_capture

`default_nettype wire

// *** tb/tmc_cap_drv.sv ***
// board-side model of the four capture pins
`timescale 1ns/1ps
`default_nettype none

module tmc_cap_drv (
  // clock and requested pin levels
  input wire logic pclk,
  input wire logic [3:0] want,
  // pins towards the block
  output logic [3:0] cap_in
);
  // pins move just after an edge, like a synchronous source
  always_ff @(posedge pclk)
    cap_in <= want;
endmodule // tmc_cap_drv

`default_nettype wire

// *** tb/tmc_checker.sv ***
// checker: bus handshake, setup read-back and capture irq timing
`timescale 1ns/1ps
`default_nettype none

module tmc_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire tmc_pkg::tmc_apb_req_t apb_req,
  input wire tmc_pkg::tmc_apb_rsp_t apb_rsp,
  // pins
  input wire logic [3:0] cap_in,
  input wire logic irq
);
  import tmc_pkg::*;
  logic wr;
  logic [11:0] mca_sh;
  logic [11:0] cap_sh;
  // shadow of setup writes so the irq enables are known here
  assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready
    && apb_req.pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mca_sh <= '0;
      cap_sh <= '0;
    end
    else if (wr)
    begin
      if (apb_req.paddr == TMC_OFF_COMPARE_ACTION)
        mca_sh <= apb_req.pwdata[11:0];
      if (apb_req.paddr == TMC_OFF_CAPTURE_SETUP)
        cap_sh <= apb_req.pwdata[11:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // flag and irq register at the edge that sees the event
  sequence s_irq_late;
    ##1 irq;
  endsequence
  property p_ready_next;
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  property p_ready_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
  property p_rdata_idle;
    !apb_rsp.pready |-> apb_rsp.prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata idle");
  property p_reserved_zero;
    apb_rsp.pready && !apb_req.pwrite &&
    (apb_req.paddr == TMC_OFF_COMPARE_ACTION ||
    apb_req.paddr == TMC_OFF_CAPTURE_SETUP) |-> apb_rsp.prdata[31:12] == 0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits set");
  property p_cap3_rise;
    $rose(cap_in[3]) && cap_sh[9] && cap_sh[11] |-> s_irq_late;
  endproperty
  a_cap3_rise: assert property (p_cap3_rise)
    else $error("no irq on rise");
  property p_cap3_fall;
    $fell(cap_in[3]) && cap_sh[10] && cap_sh[11] |-> s_irq_late;
  endproperty
  a_cap3_fall: assert property (p_cap3_fall)
    else $error("no irq on fall");
  property p_cap0_both;
    $changed(cap_in[0]) && cap_sh[2:0] == 3'h7 |-> s_irq_late;
  endproperty
  a_cap0_both: assert property (p_cap0_both)
    else $error("no irq on edge");
  property p_flags_quiet;
    wr && apb_req.paddr == TMC_OFF_FLAGS && apb_req.pwdata[7:0] == 8'hff
    && (mca_sh & 12'h249) == 0 && (cap_sh & 12'h924) == 0 |-> ##1 !irq;
  endproperty
  a_flags_quiet: assert property (p_flags_quiet)
    else $error("irq stuck");
endmodule // tmc_checker

bind tmc_timer_match_capture tmc_checker u_chk (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .cap_in(cap_in), .irq(irq));

`default_nettype wire

// *** tb/test_timer_match_capture_ctrl.sv ***
// testbench: compare and capture timer
`timescale 1ns/1ps
`default_nettype none

module test_timer_match_capture_ctrl;
  import tmc_pkg::*;
  logic pclk;
  logic presetn;
  logic irq;
  tmc_apb_req_t req;
  tmc_apb_rsp_t rsp;
  logic [3:0] want;
  logic [3:0] cap_in;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [31:0] v;
  logic err;
  int bad_count;
  int samples_checked;
  tmc_timer_match_capture DUT (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .cap_in(cap_in), .irq(irq));
  tmc_cap_drv pins (.pclk(pclk), .want(want), .cap_in(cap_in));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung access
    do
      @(posedge pclk);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic edge_cap(input int i);
    want[i] <= ~want[i];
    repeat (4) @(posedge pclk);
    bus(1'b0, TMC_OFF_CAPTURED0 + 12'(4 * i), 32'h0);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    test_done();
  end
  initial
  begin
    seed = 32'h4f0c;
    bad_count = 0;
    samples_checked = 0;
    presetn = 1'b0;
    req = '0;
    want = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, TMC_OFF_COMPARE_ACTION + 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      bus(1'b1, TMC_OFF_COMPARE_VALUE0 + 12'(4 * i), v);
      bus(1'b0, TMC_OFF_COMPARE_VALUE0 + 12'(4 * i), 32'h0);
      chk(rd, v);
    end
    for (int k = 0; k < 2; k++)
    begin
      v = {20'h0, k ? TMC_OFF_CAPTURE_SETUP : TMC_OFF_COMPARE_ACTION};
      // software keeps reserved bits at zero
      bus(1'b1, v[11:0], 32'h00000fff);
      bus(1'b0, v[11:0], 32'h0);
      chk(rd, 32'h00000fff);
      bus(1'b1, v[11:0], 32'h0);
    end
    bus(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, TMC_OFF_FLAGS, 32'hff);
      bus(1'b1, TMC_OFF_CAPTURE_SETUP, 32'h7 << (3 * i));
      for (int e = 0; e < 2; e++)
      begin
        v = rnd();
        bus(1'b1, TMC_OFF_TICK, v);
        edge_cap(i);
        chk(rd, v);
        bus(1'b0, TMC_OFF_FLAGS, 32'h0);
        chk(rd, 32'h1 << (4 + i));
      end
      chk({31'h0, irq}, 32'h1);
    end
    bus(1'b1, TMC_OFF_CAPTURE_SETUP, 32'h400);
    bus(1'b1, TMC_OFF_TICK, 32'h5);
    edge_cap(3);
    chk(rd, v);
    edge_cap(3);
    chk(rd, 32'h5);
    bus(1'b1, TMC_OFF_PRESCALE_MAX, 32'h0);
    // action moves off the old channel before tick is rewritten
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, TMC_OFF_COMPARE_VALUE0 + 12'(4 * i), 32'(3 + i));
      bus(1'b1, TMC_OFF_COMPARE_ACTION, 32'h6 << (3 * i));
      bus(1'b1, TMC_OFF_TICK, 32'h0);
      bus(1'b1, TMC_OFF_RUN_CTRL, 32'h1);
      repeat (20) @(posedge pclk);
      bus(1'b0, TMC_OFF_TICK, 32'h0);
      chk(rd, 32'(3 + i));
      bus(1'b0, TMC_OFF_RUN_CTRL, 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'b1, TMC_OFF_FLAGS, 32'hff);
    bus(1'b1, TMC_OFF_COMPARE_ACTION, 32'h3);
    bus(1'b1, TMC_OFF_TICK, 32'h0);
    bus(1'b1, TMC_OFF_RUN_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    bus(1'b1, TMC_OFF_RUN_CTRL, 32'h0);
    bus(1'b0, TMC_OFF_TICK, 32'h0);
    chk({31'h0, rd <= 32'h3}, 32'h1);
    bus(1'b1, TMC_OFF_FLAGS, 32'h0);
    bus(1'b0, TMC_OFF_FLAGS, 32'h0);
    chk(rd, 32'h1);
    bus(1'b1, TMC_OFF_COMPARE_ACTION, 32'h0);
    bus(1'b1, TMC_OFF_CAPTURE_SETUP, 32'h0);
    bus(1'b1, TMC_OFF_FLAGS, 32'hff);
    bus(1'b0, TMC_OFF_FLAGS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    test_done();
  end
endmodule // test_timer_match_capture_ctrl

`default_nettype wire
